// ===== hw/crt_pkg.sv
// Purpose: Shared constants and carriers for the control register transfer unit
// Assumes: 16-bit data path, 23-bit segmented address (7-bit segment, 16-bit offset)
// Notes:   Operation codes are internal to this unit
package crt_pkg;

    localparam int unsigned WORD_W = 16;

    // Operation codes presented with a request
    typedef enum logic [3:0] {
        CRT_OP_LDA_NS   = 4'h0,
        CRT_OP_LDA_SEG  = 4'h1,
        CRT_OP_LOAD_RELATIVE_ADDRESS     = 4'h2,
        CRT_OP_FLAGS_WR = 4'h3,
        CRT_OP_FLAGS_RD = 4'h4,
        CRT_OP_FCW_WR   = 4'h5,
        CRT_OP_FCW_RD   = 4'h6,
        CRT_OP_REF_WR   = 4'h7,
        CRT_OP_REF_RD   = 4'h8,
        CRT_OP_SSEG_WR  = 4'h9,
        CRT_OP_SSEG_RD  = 4'hA,
        CRT_OP_SOFF_WR  = 4'hB,
        CRT_OP_SOFF_RD  = 4'hC,
        CRT_OP_NSEG_WR  = 4'hD,
        CRT_OP_NSEG_RD  = 4'hE
    } crt_op_e;

    // Write masks: bits that a load from a register may change
    localparam logic [7:0]  FLAGS_WR_MASK = 8'hFC;
    localparam logic [15:0] FCW_WR_MASK   = 16'hF8FC;
    localparam logic [15:0] REF_WR_MASK   = 16'hFFFE;
    localparam logic [15:0] SSEG_WR_MASK  = 16'h7F00;
    localparam logic [15:0] SOFF_WR_MASK  = 16'hFF00;
    // Read masks: bits returned in place, rest cleared
    localparam logic [15:0] REF_RD_MASK   = 16'h01FE;

    // Flags-and-control word fields
    localparam int unsigned FCW_SEG_BIT   = 15;
    localparam int unsigned FCW_SYS_BIT   = 14;
    localparam int unsigned FCW_VIE_BIT   = 12;
    localparam int unsigned FCW_NVIE_BIT  = 11;
    // Flag byte fields
    localparam int unsigned FLG_C_BIT     = 7;
    localparam int unsigned FLG_Z_BIT     = 6;
    localparam int unsigned FLG_S_BIT     = 5;
    localparam int unsigned FLG_PV_BIT    = 4;
    localparam int unsigned FLG_D_BIT     = 3;
    localparam int unsigned FLG_H_BIT     = 2;
    // Refresh fields
    localparam int unsigned REF_EN_BIT    = 15;
    localparam int unsigned REF_RATE_LSB  = 9;
    localparam int unsigned REF_CNT_LSB   = 1;
    // Segmented address: segment number in bits 30:24, reserved bits cleared
    localparam logic [31:0] SEG_ADDR_MASK = 32'h7F00FFFF;

    // Reset values
    localparam logic [15:0] FCW_RST  = 16'h4000;
    localparam logic [15:0] REF_RST  = 16'h0000;
    localparam logic [15:0] SSEG_RST = 16'h0000;
    localparam logic [15:0] SOFF_RST = 16'h0000;
    localparam logic [15:0] NSEG_RST = 16'h0000;

    typedef struct packed {
        crt_op_e     op;
        logic [15:0] src_word;
        logic [31:0] src_addr;
        logic [15:0] next_pc;
        logic [15:0] disp;
    } crt_req_s;

    typedef struct packed {
        logic        valid;
        logic        trap;
        logic        dst_long;
        logic [31:0] dst_data;
    } crt_rsp_s;

    typedef struct packed {
        logic [15:0] flags_control_word;
        logic [15:0] refresh;
        logic [15:0] sseg;
        logic [15:0] soff;
        logic [15:0] nseg;
        crt_rsp_s    rsp;
    } crt_state_s;

endpackage

// ===== hw/crt_unit.sv
// Purpose: Executes address loads and masked control register transfers
// Assumes: Decode supplies op, operands, effective address and next PC
// Notes:   One request per cycle; answer registered one edge later
//          Privilege is judged on the control word standing at the taking edge
//          Undefined read bits come back as zero so results stay repeatable
//
// Contract
// - Address load writes the computed operand address to destination, memory untouched.
// - Nonsegmented result is one word; segmented result fills a register pair.
// - Relative load adds signed 16-bit displacement to address after instruction.
// - Segmented relative result has all reserved bits cleared to zero.
// - Flag byte write copies source bits 2:7; low two flag bits kept.
// - Flag byte read returns bits 2:7, clears 0:1, flags unchanged.
// - Flag byte transfer allowed always; other control transfers need system mode.
// - Control word write loads bits 2:7 and 11:15, keeps 0,1,8,9,10.
// - Control word read returns 2:7 and 11:15, clears 0:1 and 8:10.
// - Refresh write loads bits 1:15, keeps bit 0.
// - Refresh read returns counter bits 1:8 only, bit 0 cleared.
// - Refresh counter occupies bits 1 through 8.
// - Status segment write loads only bits 8:14.
// - Status segment read returns 8:14, clears 0:7 and 15.
// - Status offset write loads only bits 8:15.
// - Status offset read returns 8:15, clears 0:7.
// - Normal stack segment write copies whole source word.
// - Normal stack segment read copies it out; no flags change.
`timescale 1ns/10ps
`default_nettype none

module crt_unit #(
    parameter bit SEGMENTED_PART = 1'b1
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    // Request
    input  wire logic              req_valid,
    input  wire crt_pkg::crt_req_s req,
    // Answer
    output logic                   rsp_valid,
    output logic                   rsp_trap,
    output logic                   rsp_dst_long,
    output logic [31:0]            rsp_dst_data,
    // Flags-and-control word and its mode bits
    output logic [15:0]            fcw_out,
    output logic                   seg_mode,
    output logic                   sys_mode,
    output logic                   vi_enable,
    output logic                   nvi_enable,
    // Refresh control fields
    output logic                   refresh_enable,
    output logic [5:0]             refresh_rate,
    output logic [7:0]             refresh_count,
    // Status area pointer halves and normal stack segment
    output logic [15:0]            status_area_segment,
    output logic [15:0]            status_area_offset,
    output logic [15:0]            normal_stack_segment
);

    crt_pkg::crt_state_s state_reg;
    crt_pkg::crt_state_s state_next;

    // Masked load: keep bits outside the mask
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [15:0] mask);
        merge16 = (old_v & ~mask) | (new_v & mask);
    endfunction

    // Every control register except the flag byte needs system mode
    function automatic logic needs_system_mode(input crt_pkg::crt_op_e op);
        case (op)
            crt_pkg::CRT_OP_FCW_WR,
            crt_pkg::CRT_OP_FCW_RD,
            crt_pkg::CRT_OP_REF_WR,
            crt_pkg::CRT_OP_REF_RD,
            crt_pkg::CRT_OP_SSEG_WR,
            crt_pkg::CRT_OP_SSEG_RD,
            crt_pkg::CRT_OP_SOFF_WR,
            crt_pkg::CRT_OP_SOFF_RD,
            crt_pkg::CRT_OP_NSEG_WR,
            crt_pkg::CRT_OP_NSEG_RD: begin
                needs_system_mode = 1'b1;
            end
            default: begin
                needs_system_mode = 1'b0;
            end
        endcase
    endfunction

    // Read-back view; cleared and undefined bits come back as zero
    function automatic logic [15:0] control_read(input crt_pkg::crt_op_e    op,
                                                 input crt_pkg::crt_state_s st);
        logic [15:0] view;
        view = 16'h0000;
        case (op)
            crt_pkg::CRT_OP_FLAGS_RD: begin
                view = {8'h00, st.flags_control_word[7:0] & crt_pkg::FLAGS_WR_MASK};
            end
            crt_pkg::CRT_OP_FCW_RD: begin
                view = st.flags_control_word & crt_pkg::FCW_WR_MASK;
            end
            crt_pkg::CRT_OP_REF_RD: begin
                view = st.refresh & crt_pkg::REF_RD_MASK;
            end
            crt_pkg::CRT_OP_SSEG_RD: begin
                view = st.sseg & crt_pkg::SSEG_WR_MASK;
            end
            crt_pkg::CRT_OP_SOFF_RD: begin
                view = st.soff & crt_pkg::SOFF_WR_MASK;
            end
            crt_pkg::CRT_OP_NSEG_RD: begin
                view = st.nseg;
            end
            default: begin
                view = 16'h0000;
            end
        endcase
        control_read = view;
    endfunction

    logic        priv_ok;
    logic [15:0] rel_off;
    logic [7:0]  flags_now;

    assign flags_now = state_reg.flags_control_word[7:0];
    // Unknown op codes pass here and trap in the decode below
    assign priv_ok = !needs_system_mode(req.op) || state_reg.flags_control_word[crt_pkg::FCW_SYS_BIT];
    // Offset wraps within the segment, segment number untouched
    assign rel_off = req.next_pc + req.disp;

    always_comb begin
        state_next = state_reg;
        state_next.rsp.valid    = req_valid;
        state_next.rsp.trap     = 1'b0;
        state_next.rsp.dst_long = 1'b0;
        state_next.rsp.dst_data = 32'h00000000;
        if (req_valid && !priv_ok) begin
            // Privilege fault: nothing is written
            state_next.rsp.trap = 1'b1;
        end else if (req_valid) begin
            case (req.op)
                crt_pkg::CRT_OP_LDA_NS: begin
                    state_next.rsp.dst_data = {16'h0000, req.src_addr[15:0]};
                end

                crt_pkg::CRT_OP_LDA_SEG: begin
                    // Reserved bits passed as computed; callers may not rely on them
                    state_next.rsp.dst_long = 1'b1;
                    state_next.rsp.dst_data = req.src_addr;
                end

                crt_pkg::CRT_OP_LOAD_RELATIVE_ADDRESS: begin
                    if (state_reg.flags_control_word[crt_pkg::FCW_SEG_BIT]) begin
                        state_next.rsp.dst_long = 1'b1;
                        state_next.rsp.dst_data = {req.src_addr[31:16], rel_off}
                                                  & crt_pkg::SEG_ADDR_MASK;
                    end else begin
                        state_next.rsp.dst_data = {16'h0000, rel_off};
                    end
                end

                crt_pkg::CRT_OP_FLAGS_WR: begin
                    state_next.flags_control_word[7:0] = (flags_now & ~crt_pkg::FLAGS_WR_MASK)
                                        | (req.src_word[7:0] & crt_pkg::FLAGS_WR_MASK);
                end

                crt_pkg::CRT_OP_FLAGS_RD: begin
                    state_next.rsp.dst_data = {16'h0000, control_read(req.op, state_reg)};
                end

                crt_pkg::CRT_OP_FCW_WR: begin
                    state_next.flags_control_word = merge16(state_reg.flags_control_word, req.src_word,
                                             crt_pkg::FCW_WR_MASK);
                end

                crt_pkg::CRT_OP_FCW_RD: begin
                    state_next.rsp.dst_data = {16'h0000, control_read(req.op, state_reg)};
                end

                crt_pkg::CRT_OP_REF_WR: begin
                    state_next.refresh = merge16(state_reg.refresh, req.src_word,
                                                 crt_pkg::REF_WR_MASK);
                end

                crt_pkg::CRT_OP_REF_RD: begin
                    state_next.rsp.dst_data = {16'h0000, control_read(req.op, state_reg)};
                end

                crt_pkg::CRT_OP_SSEG_WR: begin
                    state_next.sseg = merge16(state_reg.sseg, req.src_word,
                                              crt_pkg::SSEG_WR_MASK);
                end

                crt_pkg::CRT_OP_SSEG_RD: begin
                    state_next.rsp.dst_data = {16'h0000, control_read(req.op, state_reg)};
                end

                crt_pkg::CRT_OP_SOFF_WR: begin
                    state_next.soff = merge16(state_reg.soff, req.src_word,
                                              crt_pkg::SOFF_WR_MASK);
                end

                crt_pkg::CRT_OP_SOFF_RD: begin
                    state_next.rsp.dst_data = {16'h0000, control_read(req.op, state_reg)};
                end

                crt_pkg::CRT_OP_NSEG_WR: begin
                    state_next.nseg = req.src_word;
                end

                crt_pkg::CRT_OP_NSEG_RD: begin
                    state_next.rsp.dst_data = {16'h0000, control_read(req.op, state_reg)};
                end

                default: begin
                    state_next.rsp.trap = 1'b1;
                end
            endcase
        end
        // Nonsegmented part cannot enter segmented mode
        if (!SEGMENTED_PART) begin
            state_next.flags_control_word[crt_pkg::FCW_SEG_BIT] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg.flags_control_word      <= crt_pkg::FCW_RST;
            state_reg.refresh  <= crt_pkg::REF_RST;
            state_reg.sseg     <= crt_pkg::SSEG_RST;
            state_reg.soff     <= crt_pkg::SOFF_RST;
            state_reg.nseg     <= crt_pkg::NSEG_RST;
            state_reg.rsp      <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Answer
    assign rsp_valid            = state_reg.rsp.valid;
    assign rsp_trap             = state_reg.rsp.trap;
    assign rsp_dst_long         = state_reg.rsp.dst_long;
    assign rsp_dst_data         = state_reg.rsp.dst_data;

    // Control word and mode bits
    assign fcw_out              = state_reg.flags_control_word;
    assign seg_mode             = state_reg.flags_control_word[crt_pkg::FCW_SEG_BIT];
    assign sys_mode             = state_reg.flags_control_word[crt_pkg::FCW_SYS_BIT];
    assign vi_enable            = state_reg.flags_control_word[crt_pkg::FCW_VIE_BIT];
    assign nvi_enable           = state_reg.flags_control_word[crt_pkg::FCW_NVIE_BIT];

    // Refresh fields
    assign refresh_enable       = state_reg.refresh[crt_pkg::REF_EN_BIT];
    assign refresh_rate         = state_reg.refresh[crt_pkg::REF_RATE_LSB +: 6];
    assign refresh_count        = state_reg.refresh[crt_pkg::REF_CNT_LSB +: 8];

    // Pointer and stack registers
    assign status_area_segment  = state_reg.sseg;
    assign status_area_offset   = state_reg.soff;
    assign normal_stack_segment = state_reg.nseg;

endmodule

`default_nettype wire

// ===== test/crt_unit_sva.sv
// Purpose: Port-level checks for the control register transfer unit
// Assumes: Answer one edge after the taking edge
// Notes:   Privileged checks are gated on the system bit, since user mode is refused
`timescale 1ns/10ps
`default_nettype none
module crt_unit_sva (
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              arst_n,
    // Request, answer and state
    input wire logic              req_valid,
    input wire crt_pkg::crt_req_s req,
    input wire logic              rsp_trap,
    input wire logic [31:0]       rsp_dst_data,
    input wire logic [15:0]       fcw_out,
    input wire logic [7:0]        refresh_count
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_priv_trap; req_valid && req.op inside {[4'h5:4'hE]} && !fcw_out[14]
        |=> rsp_trap && rsp_dst_data == 32'h0 && $stable(fcw_out); endproperty
    a_priv_trap: assert property (p_priv_trap) else $error("user mode op not refused");
    property p_flag_wr; req_valid && req.op == crt_pkg::CRT_OP_FLAGS_WR |=> fcw_out ==
        {$past(fcw_out[15:8]), $past(req.src_word[7:2]), $past(fcw_out[1:0])}; endproperty
    a_flag_wr: assert property (p_flag_wr) else $error("flag byte write wrong");
    property p_flag_rd; req_valid && req.op == crt_pkg::CRT_OP_FLAGS_RD |=> !rsp_trap &&
        rsp_dst_data == {24'h0, $past(fcw_out[7:2]), 2'b00}; endproperty
    a_flag_rd: assert property (p_flag_rd) else $error("flag byte read wrong");
    property p_fcw_wr; req_valid && req.op == crt_pkg::CRT_OP_FCW_WR && fcw_out[14] |=>
        fcw_out == (($past(fcw_out) & 16'h0703) | ($past(req.src_word) & 16'hF8FC)); endproperty
    a_fcw_wr: assert property (p_fcw_wr) else $error("control word write wrong");
    property p_fcw_rd; req_valid && req.op == crt_pkg::CRT_OP_FCW_RD && fcw_out[14] |=>
        rsp_dst_data == {16'h0, $past(fcw_out) & 16'hF8FC}; endproperty
    a_fcw_rd: assert property (p_fcw_rd) else $error("control word read wrong");
    property p_ref_rd; req_valid && req.op == crt_pkg::CRT_OP_REF_RD && fcw_out[14] |=>
        rsp_dst_data == {23'h0, $past(refresh_count), 1'b0}; endproperty
    a_ref_rd: assert property (p_ref_rd) else $error("refresh read wrong");
    property p_load_relative_address_ns; req_valid && req.op == crt_pkg::CRT_OP_LOAD_RELATIVE_ADDRESS && !fcw_out[15] |=>
        rsp_dst_data == {16'h0, 16'($past(req.next_pc) + $past(req.disp))}; endproperty
    a_load_relative_address_ns: assert property (p_load_relative_address_ns) else $error("relative address wrong");
    property p_load_relative_address_seg; req_valid && req.op == crt_pkg::CRT_OP_LOAD_RELATIVE_ADDRESS && fcw_out[15] |=>
        rsp_dst_data == ({$past(req.src_addr[31:16]),
        16'($past(req.next_pc) + $past(req.disp))} & 32'h7F00FFFF); endproperty
    a_load_relative_address_seg: assert property (p_load_relative_address_seg) else $error("segmented relative wrong");
endmodule
bind crt_unit crt_unit_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req(req), .rsp_trap(rsp_trap), .rsp_dst_data(rsp_dst_data), .fcw_out(fcw_out),
    .refresh_count(refresh_count));
`default_nettype wire

// ===== test/crt_unit_test.sv
// Purpose: Directed scenarios for the control register transfer unit
// Assumes: Inputs move at the falling edge; answer one edge after taking
// Notes:   Requests run back to back, so each sees the previous write
`timescale 1ns/10ps
`default_nettype none
module crt_unit_test;
    logic              ref_clk, rsp_valid, rsp_trap, rsp_long, seg_m, sys_m, vi_en, nvi_en, ref_en;
    logic              arst_n = 1'b0;
    logic              req_valid = 1'b0;
    crt_pkg::crt_req_s req = '0;
    logic [5:0]        ref_rate;
    logic [7:0]        ref_cnt;
    logic [31:0]       rsp_data;
    logic [15:0]       flags_control_word, sseg, soff, nseg;
    int                n_errors = 0;
    int                num_checks = 0;
    crt_unit u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp_trap(rsp_trap), .rsp_dst_long(rsp_long),
        .rsp_dst_data(rsp_data), .fcw_out(flags_control_word), .seg_mode(seg_m), .sys_mode(sys_m),
        .vi_enable(vi_en), .nvi_enable(nvi_en), .refresh_enable(ref_en),
        .refresh_rate(ref_rate), .refresh_count(ref_cnt), .status_area_segment(sseg),
        .status_area_offset(soff), .normal_stack_segment(nseg));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Valid stays high afterwards so the next call runs back to back
    task automatic xfer(input logic [3:0] op, input logic [15:0] w, input logic [31:0] a = '0,
                        input logic [15:0] pc = '0, input logic [15:0] d = '0);
        req_valid = 1'b1;
        req = '{crt_pkg::crt_op_e'(op), w, a, pc, d};
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("answer", 64'h1, 64'(rsp_valid));
    endtask
    task automatic final_report();
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic t_ctl();
        chk("reset", 64'h4000000000000000, {flags_control_word, sseg, soff, nseg});
        xfer(4'h5, 16'hFFFF);
        xfer(4'h6, 16'h0000);
        chk("fcw", 64'hF8FCF8FC, 64'({rsp_data[15:0], flags_control_word}));
        chk("modes", 64'hF, 64'({seg_m, sys_m, vi_en, nvi_en}));
        xfer(4'h3, 16'h5503);
        chk("flags", 64'hF800, 64'(flags_control_word));
        xfer(4'h3, 16'h00A4);
        xfer(4'h4, 16'hFFFF);
        chk("flags_rd", 64'h00A4F8A4, 64'({rsp_data[15:0], flags_control_word}));
    endtask
    task automatic t_regs();
        logic [15:0] rd_exp [4] = '{16'h01FE, 16'h7F00, 16'hFF00, 16'hFFFF};
        for (int i = 0; i < 4; i++) begin
            xfer(4'(7 + 2 * i), 16'hFFFF);
            xfer(4'(8 + 2 * i), 16'h0000);
            chk("read", 64'(rd_exp[i]), 64'(rsp_data));
        end
        chk("regs", 64'h7FFF7F00FF00FFFF, {1'b0, ref_en, ref_rate, ref_cnt, sseg, soff, nseg});
        xfer(4'h7, 16'hA5A5);
        xfer(4'h8, 16'h0000);
        chk("ref2", 64'h52D201A4, 64'({ref_en, ref_rate, ref_cnt, rsp_data[15:0]}));
    endtask
    task automatic t_addr();
        xfer(4'h2, 16'h0000, 32'hFFAA0000, 16'h1000, 16'hFFFE);
        chk("load_relative_address_seg", 64'h17F000FFE, 64'({rsp_long, rsp_data}));
        xfer(4'h1, 16'h0000, 32'h81AA0028);
        chk("lda_seg", 64'h181AA0028, 64'({rsp_long, rsp_data}));
        xfer(4'h5, 16'h5000);
        chk("modes2", 64'h6, 64'({seg_m, sys_m, vi_en, nvi_en}));
        xfer(4'h2, 16'h0000, 32'h0, 16'hFFF0, 16'h7FFF);
        chk("load_relative_address", 64'h7FEF, 64'({rsp_long, rsp_data}));
    endtask
    task automatic t_priv();
        xfer(4'h5, 16'h0000);
        for (int i = 5; i < 16; i++) begin
            xfer(4'(i), 16'hFFFF);
            chk("refused", 64'h100000000, 64'({rsp_trap, rsp_data}));
        end
        chk("kept", 64'h00007F00FF00FFFF, {flags_control_word, sseg, soff, nseg});
        xfer(4'h3, 16'h00FC);
        chk("user_flags", 64'h00FC, 64'({rsp_trap, flags_control_word}));
        req_valid = 1'b0;
    endtask
    // Mid-run reset: registers and answer fall back, then the unit runs again
    task automatic t_rst();
        arst_n = 1'b0;
        @(negedge ref_clk);
        chk("rst_regs", 64'h4000000000000000, {flags_control_word, sseg, soff, nseg});
        chk("rst_rsp", 64'h0, 64'({rsp_valid, rsp_trap, rsp_long, rsp_data}));
        arst_n = 1'b1;
        @(negedge ref_clk);
        chk("rst_ref", 64'h0, 64'({ref_en, ref_rate, ref_cnt}));
        xfer(4'h6, 16'h0000);
        chk("rst_fcw", 64'h4000, 64'({rsp_trap, rsp_data}));
        req_valid = 1'b0;
        @(negedge ref_clk);
        chk("idle", 64'h0, 64'(rsp_valid));
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        t_ctl();
        t_regs();
        t_addr();
        t_priv();
        t_rst();
        final_report();
    end
endmodule
`default_nettype wire
